/* File: src/npucp_decoder.sv */
// long-form parameter command decoder with register readback
// Function
// - bits 15:14 equal to 01 mark long form; code in low ten bits; one payload word follows
// - offsets, strides and lengths are kept as byte counts
// - extension field accepted but addresses held to 32 bits
// - 0x014/0x015 load output map horizontal and vertical byte steps
// - 0x016 loads output map step between sixteen-byte channel blocks
// - 0x020/0x090 load coefficient stream offsets, unsigned extension
// - 0x021/0x091 load 32-bit coefficient stream lengths
// - 0x022/0x092 load bias stream offsets from scale region start
// - 0x023/0x093 load bias stream lengths, 20 bits kept
// - 0x024 loads 32-bit output scale and 6-bit shift
// - 32-bit operations use output shift but skip output scale
// - 0x025 sets operand A; mode 0 ignores shift, 16-bit scale
// - modes 1 and 2 use 6-bit shift; scale 32 or 16 bits
// - 0x026 sets 16-bit operand B scale, used only in mode 0
// - 0x030/0x031 load channel 0 source and destination offsets
// - 0x032 loads channel 0 one-dimensional transfer length
// - 0x033 loads gap after each inner transfer, any alignment
// - 0x034 loads gap after each two-dimensional transfer
// - 0x080..0x083 load second input map tile offsets
// - 0x084..0x086 load second input map signed steps
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module npucp_decoder (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic word_valid_i,
    input wire logic [31:0] word_i,
    output logic word_ready_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic [31:0] out_map_horiz_step_o,
    output logic [31:0] out_map_vert_step_o,
    output logic [31:0] out_map_chanblk_step_o,
    output logic [31:0] coef_stream_a_offset_o,
    output logic [31:0] coef_stream_a_len_o,
    output logic [31:0] bias_stream_a_offset_o,
    output logic [31:0] bias_stream_a_len_o,
    output logic [31:0] coef_stream_b_offset_o,
    output logic [31:0] coef_stream_b_len_o,
    output logic [31:0] bias_stream_b_offset_o,
    output logic [31:0] bias_stream_b_len_o,
    output logic [31:0] output_rescale_o,
    output logic [5:0] output_shift_o,
    output logic output_scale_apply_o,
    output logic [5:0] operand_a_shift_o,
    output logic [31:0] operand_a_rescale_o,
    output logic [31:0] operand_b_rescale_o,
    output logic [31:0] dma_ch0_src_offset_o,
    output logic [31:0] dma_ch0_dst_offset_o,
    output logic [31:0] dma_ch0_length_o,
    output logic [31:0] dma_ch0_inner_gap_o,
    output logic [31:0] dma_ch0_plane_gap_o,
    output logic [31:0] second_in_tile0_offset_o,
    output logic [31:0] second_in_tile1_offset_o,
    output logic [31:0] second_in_tile2_offset_o,
    output logic [31:0] second_in_tile3_offset_o,
    output logic [31:0] second_in_horiz_step_o,
    output logic [31:0] second_in_vert_step_o,
    output logic [31:0] second_in_chanblk_step_o
);
    // returns {hit, slot index}
    function automatic logic [5:0] slot_lookup(input logic [9:0] c);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < npucp_pkg::NSLOT; i++) begin
            if (npucp_pkg::SLOT_CODE[i] == c) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction

    npucp_pkg::npucp_state_e state;
    logic [9:0] code_q;
    logic [15:0] param_q;
    logic [31:0] ctrl;
    logic [npucp_pkg::NSLOT-1:0][31:0] slot_q;
    logic [npucp_pkg::NSLOT-1:0] load_vec;
    logic [5:0] out_shift_q;
    logic [5:0] opa_shift_q;
    logic unknown_seen;
    logic ext_dropped;
    logic [15:0] long_cnt;
    logic [5:0] hit_idx;
    logic accept;
    logic is_long;
    logic pay_acc;
    logic ext_bad;
    logic [1:0] mode;
    logic stat_wr;

    assign word_ready_o = ctrl[npucp_pkg::CTRL_EN];
    assign accept = word_valid_i && word_ready_o;
    assign is_long = word_i[npucp_pkg::KIND_HI:npucp_pkg::KIND_LO] == npucp_pkg::LONG_KIND;
    assign pay_acc = accept && (state == npucp_pkg::ST_PAY);
    assign hit_idx = slot_lookup(code_q);
    assign mode = ctrl[npucp_pkg::CTRL_MODE_LO +: 2];
    assign stat_wr = reg_wr_i && (reg_addr_i == npucp_pkg::A_STAT);

    // long header then exactly one payload word; a short word takes no payload
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state <= npucp_pkg::ST_HDR;
        end else if (accept) begin
            case (state)
                npucp_pkg::ST_HDR: begin
                    if (is_long) begin
                        state <= npucp_pkg::ST_PAY;
                    end
                end
                npucp_pkg::ST_PAY: begin
                    state <= npucp_pkg::ST_HDR;
                end
                default: begin
                    state <= npucp_pkg::ST_HDR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            code_q <= 10'h000;
            param_q <= 16'h0000;
        end else if (accept && state == npucp_pkg::ST_HDR && is_long) begin
            code_q <= word_i[npucp_pkg::CODE_W-1:0];
            param_q <= word_i[npucp_pkg::PARAM_LSB +: 16];
        end
    end

    // unknown code: no slot selected, nothing loads
    for (genvar g = 0; g < npucp_pkg::NSLOT; g++) begin : g_slot
        assign load_vec[g] = pay_acc && hit_idx[5] && (hit_idx[4:0] == 5'(g));
        npucp_slot #(
            .W(npucp_pkg::SLOT_W[g])
        ) u_slot (
            .core_clk_i(core_clk_i),
            .rstn_i(rstn_i),
            .load_i(load_vec[g]),
            .data_i(word_i),
            .value_o(slot_q[g])
        );
    end

    // payload kept as printed byte count, no scaling
    assign out_map_horiz_step_o = slot_q[npucp_pkg::S_OUT_H];
    assign out_map_vert_step_o = slot_q[npucp_pkg::S_OUT_V];
    assign out_map_chanblk_step_o = slot_q[npucp_pkg::S_OUT_C];
    assign coef_stream_a_offset_o = slot_q[npucp_pkg::S_COEF_A_OFS];
    assign coef_stream_b_offset_o = slot_q[npucp_pkg::S_COEF_B_OFS];
    assign coef_stream_a_len_o = slot_q[npucp_pkg::S_COEF_A_LEN];
    assign coef_stream_b_len_o = slot_q[npucp_pkg::S_COEF_B_LEN];
    assign bias_stream_a_offset_o = slot_q[npucp_pkg::S_BIAS_A_OFS];
    assign bias_stream_b_offset_o = slot_q[npucp_pkg::S_BIAS_B_OFS];
    assign bias_stream_a_len_o = slot_q[npucp_pkg::S_BIAS_A_LEN];
    assign bias_stream_b_len_o = slot_q[npucp_pkg::S_BIAS_B_LEN];
    assign output_rescale_o = slot_q[npucp_pkg::S_OUT_SCALE];
    assign dma_ch0_src_offset_o = slot_q[npucp_pkg::S_DMA_SRC];
    assign dma_ch0_dst_offset_o = slot_q[npucp_pkg::S_DMA_DST];
    assign dma_ch0_length_o = slot_q[npucp_pkg::S_DMA_LEN];
    assign dma_ch0_inner_gap_o = slot_q[npucp_pkg::S_DMA_GAP0];
    assign dma_ch0_plane_gap_o = slot_q[npucp_pkg::S_DMA_GAP1];
    assign second_in_tile0_offset_o = slot_q[npucp_pkg::S_TILE0];
    assign second_in_tile1_offset_o = slot_q[npucp_pkg::S_TILE1];
    assign second_in_tile2_offset_o = slot_q[npucp_pkg::S_TILE2];
    assign second_in_tile3_offset_o = slot_q[npucp_pkg::S_TILE3];
    assign second_in_horiz_step_o = slot_q[npucp_pkg::S_SEC_H];
    assign second_in_vert_step_o = slot_q[npucp_pkg::S_SEC_V];
    assign second_in_chanblk_step_o = slot_q[npucp_pkg::S_SEC_C];

    // shifts come from the parameter field
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            out_shift_q <= 6'h00;
            opa_shift_q <= 6'h00;
        end else if (load_vec[npucp_pkg::S_OUT_SCALE]) begin
            out_shift_q <= param_q[npucp_pkg::SHIFT_W-1:0];
        end else if (load_vec[npucp_pkg::S_OPA_SCALE]) begin
            opa_shift_q <= param_q[npucp_pkg::SHIFT_W-1:0];
        end
    end

    // upper address bits cannot be held: flag an extension that is not zero (unsigned slots) or the payload sign (signed slots)
    always_comb begin
        ext_bad = 1'b0;
        if (hit_idx[5]) begin
            case (npucp_pkg::SLOT_EXT[hit_idx[4:0]])
                npucp_pkg::EXT_U: ext_bad = (param_q != 16'h0000);
                npucp_pkg::EXT_S: ext_bad = (param_q != {16{word_i[31]}});
                default: ext_bad = 1'b0;
            endcase
        end
    end

    // sticky flags, set beats a write-one clear
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            unknown_seen <= 1'b0;
            ext_dropped <= 1'b0;
        end else begin
            if (pay_acc && !hit_idx[5]) begin
                unknown_seen <= 1'b1;
            end else if (stat_wr && reg_wdata_i[npucp_pkg::STAT_UNK]) begin
                unknown_seen <= 1'b0;
            end
            if (pay_acc && ext_bad) begin
                ext_dropped <= 1'b1;
            end else if (stat_wr && reg_wdata_i[npucp_pkg::STAT_EXT]) begin
                ext_dropped <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            long_cnt <= 16'h0000;
        end else if (pay_acc) begin
            long_cnt <= long_cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ctrl <= npucp_pkg::CTRL_RESET;
        end else if (reg_wr_i && reg_addr_i == npucp_pkg::A_CTRL) begin
            ctrl <= {28'h0000000, reg_wdata_i[3:0]};
        end
    end

    // scaling views that the datapath engines use
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            output_shift_o <= 6'h00;
            output_scale_apply_o <= 1'b1;
            operand_a_shift_o <= 6'h00;
            operand_a_rescale_o <= 32'h0000_0000;
            operand_b_rescale_o <= 32'h0000_0000;
        end else begin
            output_shift_o <= out_shift_q;
            output_scale_apply_o <= !ctrl[npucp_pkg::CTRL_PREC32];
            operand_a_shift_o <= (mode == npucp_pkg::MODE_PLAIN) ? 6'h00 : opa_shift_q;
            if (mode == npucp_pkg::MODE_WIDE) begin
                operand_a_rescale_o <= slot_q[npucp_pkg::S_OPA_SCALE];
            end else begin
                operand_a_rescale_o <= {16'h0000, slot_q[npucp_pkg::S_OPA_SCALE][15:0]};
            end
            if (mode == npucp_pkg::MODE_PLAIN) begin
                operand_b_rescale_o <= {16'h0000, slot_q[npucp_pkg::S_OPB_SCALE][15:0]};
            end else begin
                operand_b_rescale_o <= 32'h0000_0000;
            end
        end
    end

    // register readback, data in the cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i < npucp_pkg::A_SLOT_END && reg_addr_i[1:0] == 2'h0) begin
                reg_rdata_o <= slot_q[reg_addr_i[6:2]];
            end else begin
                case (reg_addr_i)
                    npucp_pkg::A_CTRL: reg_rdata_o <= ctrl;
                    npucp_pkg::A_STAT: reg_rdata_o <= {long_cnt, 13'h0000, ext_dropped,
                        unknown_seen, state == npucp_pkg::ST_PAY};
                    npucp_pkg::A_SHIFT: reg_rdata_o <= {18'h00000, opa_shift_q, 2'h0,
                        out_shift_q};
                    npucp_pkg::A_LAST: reg_rdata_o <= {param_q, 6'h00, code_q};
                    default: reg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    a_long_hdr_wait: assert property (accept && state == npucp_pkg::ST_HDR && is_long
        |=> state == npucp_pkg::ST_PAY ##0 code_q == $past(word_i[9:0]))
        else $error("long header did not wait for payload");
    a_short_hdr_stay: assert property (accept && state == npucp_pkg::ST_HDR && !is_long
        |=> state == npucp_pkg::ST_HDR)
        else $error("short word took a payload slot");
    a_hstep_load: assert property (pay_acc && code_q == 10'h014
        |=> out_map_horiz_step_o == $past(word_i) && state == npucp_pkg::ST_HDR)
        else $error("horizontal step not loaded from payload");
    a_bias_len_trunc: assert property (pay_acc && code_q == 10'h093
        |=> bias_stream_b_len_o == {12'h000, $past(word_i[19:0])})
        else $error("bias length not cut to 20 bits");
    a_unknown_hold: assert property (pay_acc && !hit_idx[5]
        |=> $stable(slot_q) && $stable(out_shift_q) && unknown_seen)
        else $error("unassigned code changed a value");
    a_slot_persist: assert property (!pay_acc |=> $stable(slot_q))
        else $error("value changed without a command");
    a_out_shift_load: assert property (pay_acc && code_q == 10'h024
        |=> out_shift_q == $past(param_q[5:0]) ##1 output_shift_o == $past(out_shift_q))
        else $error("output shift not taken from parameter");
    a_prec32_noscale: assert property (ctrl[npucp_pkg::CTRL_PREC32]
        |=> !output_scale_apply_o)
        else $error("scale applied at 32-bit precision");
    a_opb_mode_gate: assert property (mode != npucp_pkg::MODE_PLAIN
        |=> operand_b_rescale_o == 32'h0000_0000)
        else $error("operand B scale used outside mode 0");
    a_opa_mode0: assert property (mode == npucp_pkg::MODE_PLAIN
        |=> operand_a_shift_o == 6'h00 && operand_a_rescale_o[31:16] == 16'h0000)
        else $error("operand A mode 0 not narrowed");
    a_chanblk_load: assert property (pay_acc && code_q == 10'h016
        |=> out_map_chanblk_step_o == $past(word_i))
        else $error("channel block step not loaded");
    a_coef_ofs_load: assert property (pay_acc && code_q == 10'h020
        |=> coef_stream_a_offset_o == $past(word_i))
        else $error("coefficient offset not loaded");
    a_bias_ofs_load: assert property (pay_acc && code_q == 10'h022
        |=> bias_stream_a_offset_o == $past(word_i))
        else $error("bias offset not loaded");
    a_dma_len_load: assert property (pay_acc && code_q == 10'h032
        |=> dma_ch0_length_o == $past(word_i))
        else $error("transfer length not loaded");
    a_inner_gap_load: assert property (pay_acc && code_q == 10'h033
        |=> dma_ch0_inner_gap_o == $past(word_i))
        else $error("inner gap not loaded");
    a_plane_gap_load: assert property (pay_acc && code_q == 10'h034
        |=> dma_ch0_plane_gap_o == $past(word_i))
        else $error("plane gap not loaded");
    a_tile_ofs_load: assert property (pay_acc && code_q == 10'h083
        |=> second_in_tile3_offset_o == $past(word_i))
        else $error("tile offset not loaded");
    a_sec_step_load: assert property (pay_acc && code_q == 10'h086
        |=> second_in_chanblk_step_o == $past(word_i))
        else $error("second map step not loaded");
    a_ext_flag_set: assert property (pay_acc && ext_bad |=> ext_dropped)
        else $error("dropped extension not flagged");
    a_opa_wide_mode: assert property (mode == npucp_pkg::MODE_WIDE
        |=> operand_a_rescale_o == $past(slot_q[npucp_pkg::S_OPA_SCALE])
        && operand_a_shift_o == $past(opa_shift_q))
        else $error("operand A wide mode not applied");
endmodule // npucp_decoder
`default_nettype wire

/* File: src/npucp_pkg.sv */
// constants for the long-form parameter command decoder
package npucp_pkg;
    localparam int NSLOT = 26;
    // header word layout
    localparam int KIND_HI = 15;
    localparam int KIND_LO = 14;
    localparam logic [1:0] LONG_KIND = 2'h1;
    localparam int CODE_W = 10;
    localparam int PARAM_LSB = 16;
    localparam int SHIFT_W = 6;
    localparam int HALF_W = 16;
    // extension kinds of the parameter field
    localparam logic [1:0] EXT_U = 2'h0;
    localparam logic [1:0] EXT_S = 2'h1;
    localparam logic [1:0] EXT_N = 2'h2;
    // slot indices
    localparam int S_OUT_H = 0, S_OUT_V = 1, S_OUT_C = 2;
    localparam int S_COEF_A_OFS = 3, S_COEF_A_LEN = 4, S_BIAS_A_OFS = 5, S_BIAS_A_LEN = 6;
    localparam int S_OUT_SCALE = 7, S_OPA_SCALE = 8, S_OPB_SCALE = 9;
    localparam int S_DMA_SRC = 10, S_DMA_DST = 11, S_DMA_LEN = 12, S_DMA_GAP0 = 13;
    localparam int S_DMA_GAP1 = 14, S_TILE0 = 15, S_TILE1 = 16, S_TILE2 = 17, S_TILE3 = 18;
    localparam int S_SEC_H = 19, S_SEC_V = 20, S_SEC_C = 21;
    localparam int S_COEF_B_OFS = 22, S_COEF_B_LEN = 23, S_BIAS_B_OFS = 24, S_BIAS_B_LEN = 25;
    // command codes, in slot order
    localparam logic [9:0] SLOT_CODE [NSLOT] = '{
        10'h014, 10'h015, 10'h016, 10'h020, 10'h021, 10'h022, 10'h023,
        10'h024, 10'h025, 10'h026, 10'h030, 10'h031, 10'h032, 10'h033,
        10'h034, 10'h080, 10'h081, 10'h082, 10'h083, 10'h084, 10'h085,
        10'h086, 10'h090, 10'h091, 10'h092, 10'h093};
    localparam int LEN20_W = 20;
    localparam int FULL_W = 32;
    localparam int SLOT_W [NSLOT] = '{
        32, 32, 32, 32, 32, 32, LEN20_W, 32, 32, 32, 32, 32, 32, 32,
        32, 32, 32, 32, 32, 32, 32, 32, 32, 32, 32, LEN20_W};
    localparam logic [1:0] SLOT_EXT [NSLOT] = '{
        EXT_S, EXT_S, EXT_S, EXT_U, EXT_N, EXT_U, EXT_N, EXT_N, EXT_N, EXT_N,
        EXT_U, EXT_U, EXT_U, EXT_U, EXT_U, EXT_U, EXT_U, EXT_U, EXT_U,
        EXT_S, EXT_S, EXT_S, EXT_U, EXT_N, EXT_U, EXT_N};
    // register map
    localparam logic [7:0] A_SLOT_END = 8'h68;
    localparam logic [7:0] A_CTRL = 8'h80;
    localparam logic [7:0] A_STAT = 8'h84;
    localparam logic [7:0] A_SHIFT = 8'h88;
    localparam logic [7:0] A_LAST = 8'h8C;
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_PREC32 = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int STAT_PAY = 0;
    localparam int STAT_UNK = 1;
    localparam int STAT_EXT = 2;
    localparam int STAT_CNT_LSB = 16;
    localparam int SHIFT_OPA_LSB = 8;
    localparam logic [1:0] MODE_WIDE = 2'h1;
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    typedef enum logic {ST_HDR = 1'b0, ST_PAY = 1'b1} npucp_state_e;
endpackage

/* File: src/npucp_slot.sv */
// one persistent parameter slot, stored at its significant width
`timescale 1ns/1ps
`default_nettype none
module npucp_slot #(
    parameter int W = 32
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire logic [31:0] data_i,
    output logic [31:0] value_o
);
    logic [W-1:0] val;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            val <= '0;
        end else if (load_i) begin
            val <= data_i[W-1:0];
        end
    end

    if (W < 32) begin : g_pad
        assign value_o = {{(32-W){1'b0}}, val};
    end else begin : g_full
        assign value_o = val;
    end
endmodule // npucp_slot
`default_nettype wire

/* File: testbench/npucp_cmd_source.sv */
// command stream source standing in for the memory behind the fetcher
`timescale 1ns/1ps
`default_nettype none
module npucp_cmd_source (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ready_i,
    input wire logic slow_i,
    output logic valid_o,
    output logic [31:0] word_o,
    output logic idle_o
);
    logic [31:0] fifo [$];
    // only words queued by the bench are offered
    function automatic void push(input logic [31:0] w);
        fifo.push_back(w);
    endfunction
    initial begin
        valid_o = 1'b0;
        word_o = 32'h0;
        idle_o = 1'b1;
    end
    // word held until taken; header and payload leave in queue order
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            valid_o <= 1'b0;
        end else if (!(valid_o && !ready_i)) begin
            if (valid_o) begin
                void'(fifo.pop_front());
            end
            if (fifo.size() > 0 && (!slow_i || $urandom_range(1, 0) == 1)) begin
                valid_o <= 1'b1;
                word_o <= fifo[0];
            end else begin
                valid_o <= 1'b0;
                // idle line inverts its word each cycle, so the last word returns every second idle cycle
                word_o <= ~word_o;
            end
        end
        idle_o <= (fifo.size() == 0);
    end
endmodule // npucp_cmd_source
`default_nettype wire

/* File: testbench/tb_npucp_decoder.sv */
// self-checking bench for the long-form parameter command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_npucp_decoder;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic slow = 1'b0;
    logic word_valid, word_ready, src_idle, scale_apply;
    logic [31:0] word, reg_rdata, rd_val, opa_scale, opb_scale, pay;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [5:0] out_shift, opa_shift;
    logic [31:0] po [26];
    logic [31:0] exp_slot [26];
    logic [9:0] codes [26] = '{10'h014, 10'h015, 10'h016, 10'h020, 10'h021, 10'h022, 10'h023,
        10'h024, 10'h025, 10'h026, 10'h030, 10'h031, 10'h032, 10'h033, 10'h034, 10'h080,
        10'h081, 10'h082, 10'h083, 10'h084, 10'h085, 10'h086, 10'h090, 10'h091, 10'h092, 10'h093};
    logic [9:0] bad [6] = '{10'h017, 10'h027, 10'h035, 10'h087, 10'h094, 10'h3FF};
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #25 core_clk_i = ~core_clk_i;
    npucp_cmd_source i_src (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ready_i(word_ready),
        .slow_i(slow), .valid_o(word_valid), .word_o(word), .idle_o(src_idle));
    npucp_decoder i_dut (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .word_valid_i(word_valid), .word_i(word),
        .word_ready_o(word_ready), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .out_map_horiz_step_o(po[0]), .out_map_vert_step_o(po[1]),
        .out_map_chanblk_step_o(po[2]), .coef_stream_a_offset_o(po[3]),
        .coef_stream_a_len_o(po[4]), .bias_stream_a_offset_o(po[5]),
        .bias_stream_a_len_o(po[6]), .output_rescale_o(po[7]),
        .dma_ch0_src_offset_o(po[10]), .dma_ch0_dst_offset_o(po[11]),
        .dma_ch0_length_o(po[12]), .dma_ch0_inner_gap_o(po[13]), .dma_ch0_plane_gap_o(po[14]),
        .second_in_tile0_offset_o(po[15]), .second_in_tile1_offset_o(po[16]),
        .second_in_tile2_offset_o(po[17]), .second_in_tile3_offset_o(po[18]),
        .second_in_horiz_step_o(po[19]), .second_in_vert_step_o(po[20]),
        .second_in_chanblk_step_o(po[21]), .coef_stream_b_offset_o(po[22]),
        .coef_stream_b_len_o(po[23]), .bias_stream_b_offset_o(po[24]),
        .bias_stream_b_len_o(po[25]), .output_shift_o(out_shift),
        .output_scale_apply_o(scale_apply), .operand_a_shift_o(opa_shift),
        .operand_a_rescale_o(opa_scale), .operand_b_rescale_o(opb_scale));
    task automatic report_and_stop();
        if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] keep_bits(input logic [9:0] code, input logic [31:0] p);
        return (code == 10'h023 || code == 10'h093) ? {12'h000, p[19:0]} : p;
    endfunction
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk_i);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk_i);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic send(input logic [9:0] code, input logic [15:0] prm, input logic [31:0] p);
        i_src.push({prm, 2'h1, 4'h0, code});
        i_src.push(p);
    endtask
    task automatic settle();
        int n;
        n = 0;
        repeat (2) @(posedge core_clk_i);
        #1;
        while (!src_idle && n < 2000) begin
            @(posedge core_clk_i);
            #1 n++;
        end
        chk("stream drained", 32'h1, {31'h0, src_idle});
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic check_all();
        for (int i = 0; i < 26; i++) begin
            reg_read(8'(4 * i), rd_val);
            chk("slot readback", exp_slot[i], rd_val);
            if (i != 8 && i != 9) chk("slot port", exp_slot[i], po[i]);
        end
    endtask
    initial begin
        int k;
        logic [31:0] pa, pb;
        k = $urandom(21);
        for (int i = 0; i < 26; i++) exp_slot[i] = 32'h0;
        repeat (6) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        @(posedge core_clk_i);
        #1 chk("ready after reset", 32'h1, {31'h0, word_ready});
        chk("scale apply after reset", 32'h1, {31'h0, scale_apply});
        check_all();
        // short-form word is one word only, next long pair must land
        i_src.push({16'hFFFF, 2'h0, 4'h0, 10'h014});
        send(10'h015, 16'hFFFF, 32'h8000_0001);
        exp_slot[1] = 32'h8000_0001;
        settle();
        check_all();
        for (int r = 0; r < 4; r++) begin
            slow <= r[0];
            for (int n = 0; n < 30; n++) begin
                k = $urandom_range(31, 0);
                pay = $urandom;
                if (k < 26) begin
                    send(codes[k], 16'($urandom), pay);
                    exp_slot[k] = keep_bits(codes[k], pay);
                end else begin
                    send(bad[k - 26], 16'($urandom), pay);
                end
            end
            settle();
            check_all();
        end
        reg_write(8'h84, 32'h0000_0006);
        send(10'h01F, 16'h0, 32'hFFFF_FFFF);
        send(10'h030, 16'h0001, 32'h0000_0040);
        exp_slot[10] = 32'h0000_0040;
        reg_write(8'h00, 32'h1357_9BDF);
        settle();
        reg_read(8'h84, rd_val);
        chk("unknown code flag", 32'h1, {31'h0, rd_val[1]});
        chk("extension dropped flag", 32'h1, {31'h0, rd_val[2]});
        reg_read(8'h70, rd_val);
        chk("unmapped read", 32'h0, rd_val);
        check_all();
        reg_write(8'h80, 32'h0);
        #1 chk("ready while disabled", 32'h0, {31'h0, word_ready});
        send(10'h016, 16'h0, 32'hFFFF_FFF0);
        repeat (10) @(posedge core_clk_i);
        chk("step held while disabled", exp_slot[2], po[2]);
        reg_write(8'h80, 32'h1);
        settle();
        chk("step after enable", 32'hFFFF_FFF0, po[2]);
        exp_slot[2] = 32'hFFFF_FFF0;
        pa = $urandom;
        pb = $urandom;
        send(10'h024, 16'h002B, 32'hFEDC_BA98);
        send(10'h025, 16'h0015, pa);
        send(10'h026, 16'hFFFF, pb);
        exp_slot[7] = 32'hFEDC_BA98;
        exp_slot[8] = pa;
        exp_slot[9] = pb;
        for (int m = 0; m < 3; m++) begin
            reg_write(8'h80, {28'h0, (m == 1), 2'(m), 1'b1});
            settle();
            chk("output shift", 32'h2B, {26'h0, out_shift});
            chk("scale apply", {31'h0, (m != 1)}, {31'h0, scale_apply});
            chk("operand a shift", (m == 0) ? 32'h0 : 32'h15, {26'h0, opa_shift});
            chk("operand a scale", (m == 1) ? pa : {16'h0, pa[15:0]}, opa_scale);
            chk("operand b scale", (m == 0) ? {16'h0, pb[15:0]} : 32'h0, opb_scale);
        end
        check_all();
        report_and_stop();
    end
endmodule // tb_npucp_decoder
`default_nettype wire
